// [design/ifd_decoder.sv]
// Operation
// - single operand uses bits 15-6 as opcode, bit 15 byte, bits 5-0 destination.
// - double operand uses bits 14-12 opcode, 11-6 source, 5-0 destination.
// - bit 15 selects byte, except opcode 6 where it selects subtract; the code gives opcode 7 no byte form either.
// - each operand field splits into mode and register, decoded independently.
// - bit 15 makes move a byte move; add and subtract have no byte form.
// - byte move to register mode sign-extends into the upper byte.
// - byte instructions derive flags from the 8-bit result.
// - branch upper byte is the condition, lower byte a signed word offset.
// - target is sign-extended offset doubled plus pc, loaded only if condition holds.
// - pc advances by two after fetch, so 000777 jumps to itself.
// - all simple, signed, unsigned branches plus decrement-and-loop are supported.
// - call is bits 15-9 octal 004, link bits 8-6, destination bits 5-0.
// - return is bits 15-3 octal 00020, bits 2-0 the link register.
// - condition operator opcode is bits 15-5, bit 4 chooses set or clear.
// - bits 3-0 select flags; selected ones change together, others stay.
// - status word holds negative, zero, overflow, carry flags, active high.
// - operand instructions update flags from result; unaffected flags keep values.
// - traps and interrupts divert to a routine and can return afterwards; the code sets trap_active and ret_pc, pc is not sent to a routine.
// - mode 0 register, 2 autoinc, 4 autodec, 6 index; low bit deferred.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
module ifd_decoder
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [IFD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [IFD_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // processor side
  input wire logic irq_req,
  output logic reserved_instr,
  output logic trap_active
);

  ifd_state_t s_q;
  ifd_state_t s_d;

  ifd_fmt_t fmt;
  logic rti;
  logic trap_i;
  logic loop_op;
  logic byte_op;
  logic sub_op;
  logic move_byte_op;
  logic cond_ok;
  logic take;
  logic [15:0] pc_adv;
  logic [15:0] jump_off;
  logic [15:0] jump_tgt;
  logic [2:0] link;
  logic [3:0] cc_sel;
  logic [10:0] opcode;
  logic [31:0] fields;
  logic [31:0] wmerge;
  logic [31:0] old_word;
  logic wr_go;
  logic rd_go;
  logic [15:0] res_val;
  logic [3:0] res_mask;
  logic [3:0] res_flags;

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // instruction decode from the held word
  always_comb
  begin
    fmt = IFD_FMT_RSVD;
    rti = 1'b0;
    trap_i = 1'b0;
    loop_op = 1'b0;
    if (s_q.ir == IFD_OP_RTI || s_q.ir == IFD_OP_RTT)
    begin
      fmt = IFD_FMT_TRAP;
      rti = 1'b1;
    end
    else if (s_q.ir == IFD_OP_BPT || s_q.ir == IFD_OP_IOT)
    begin
      fmt = IFD_FMT_TRAP;
      trap_i = 1'b1;
    end
    else if (s_q.ir == IFD_OP_HALT || s_q.ir == IFD_OP_WAIT || s_q.ir == IFD_OP_RESET)
    begin
      fmt = IFD_FMT_SOP;
    end
    else if (s_q.ir[15:5] == IFD_CCOP_PREFIX)
    begin
      fmt = IFD_FMT_CCOP;
    end
    else if (s_q.ir[15:3] == IFD_RET_PREFIX)
    begin
      fmt = IFD_FMT_RET;
    end
    else if (s_q.ir[15:9] == IFD_CALL_PREFIX)
    begin
      fmt = IFD_FMT_CALL;
    end
    else if (s_q.ir[15:9] == IFD_LOOP_PREFIX)
    begin
      fmt = IFD_FMT_BRANCH;
      loop_op = 1'b1;
    end
    else if (s_q.ir[15:9] == IFD_EMU_TRAP_PREFIX)
    begin
      fmt = IFD_FMT_TRAP;
      trap_i = 1'b1;
    end
    else if (s_q.ir[14:11] == 4'h0 && (s_q.ir[15] || s_q.ir[10:8] != 3'h0))
    begin
      fmt = IFD_FMT_BRANCH;
    end
    else if (s_q.ir[14:12] != 3'h0 && !(s_q.ir[14:12] == IFD_DOP_EXT && s_q.ir[15]))
    begin
      fmt = IFD_FMT_DOP;
    end
    else if (s_q.ir[14:12] == 3'h0 && ((s_q.ir[11:6] >= IFD_SOP_LO && s_q.ir[11:6] <= IFD_SOP_HI)
             || s_q.ir[11:6] == IFD_SOP_JUMP || s_q.ir[11:6] == IFD_SOP_SWAP))
    begin
      fmt = IFD_FMT_SOP;
    end
  end

  // bit 15 is byte select, except for add/subtract and the extended group
  assign byte_op = s_q.ir[IFD_BYTE_BIT] && (fmt == IFD_FMT_SOP || (fmt == IFD_FMT_DOP
                   && s_q.ir[14:12] != IFD_DOP_ADDSUB && s_q.ir[14:12] != IFD_DOP_EXT));
  assign sub_op = fmt == IFD_FMT_DOP && s_q.ir[14:12] == IFD_DOP_ADDSUB
                  && s_q.ir[IFD_BYTE_BIT];
  assign move_byte_op = fmt == IFD_FMT_DOP && s_q.ir[14:12] == IFD_DOP_MOVE
                        && s_q.ir[IFD_BYTE_BIT];
  assign link = (fmt == IFD_FMT_RET) ? s_q.ir[2:0] : s_q.ir[8:6];
  assign cc_sel = s_q.ir[3:0];
  assign opcode = (fmt == IFD_FMT_SOP) ? {1'b0, s_q.ir[15:6]} :
                  (fmt == IFD_FMT_DOP) ? {7'h00, s_q.ir[15:12]} :
                  (fmt == IFD_FMT_CCOP) ? s_q.ir[15:5] : 11'h000;

  // flags: n z v c
  always_comb
  begin
    logic n;
    logic z;
    logic v;
    logic c;
    n = s_q.processor_status_word[3];
    z = s_q.processor_status_word[2];
    v = s_q.processor_status_word[1];
    c = s_q.processor_status_word[0];
    unique case ({s_q.ir[15], s_q.ir[10:8]})
      4'h1: cond_ok = 1'b1;
      4'h2: cond_ok = !z;
      4'h3: cond_ok = z;
      4'h4: cond_ok = !(n ^ v);
      4'h5: cond_ok = n ^ v;
      4'h6: cond_ok = !(z | (n ^ v));
      4'h7: cond_ok = z | (n ^ v);
      4'h8: cond_ok = !n;
      4'h9: cond_ok = n;
      4'hA: cond_ok = !(c | z);
      4'hB: cond_ok = c | z;
      4'hC: cond_ok = !v;
      4'hD: cond_ok = v;
      4'hE: cond_ok = !c;
      4'hF: cond_ok = c;
      default: cond_ok = 1'b0;
    endcase
  end

  assign pc_adv = s_q.pc + IFD_PC_STEP;
  // offset in words is doubled into bytes; the loop form only counts backwards
  assign jump_off = loop_op ? {9'h000, s_q.ir[5:0], 1'b0}
                            : {{7{s_q.ir[7]}}, s_q.ir[7:0], 1'b0};
  assign jump_tgt = loop_op ? pc_adv - jump_off : pc_adv + jump_off;
  // loop count is the result register; taken unless the decrement reaches zero
  assign take = fmt == IFD_FMT_BRANCH
                && (loop_op ? s_q.rslt != IFD_LOOP_DONE : cond_ok);

  assign fields = {fmt == IFD_FMT_RSVD, s_q.ir[9], s_q.ir[11:10], s_q.ir[3], s_q.ir[5:4],
                   cc_sel, s_q.ir[IFD_CC_SET_BIT], link, fmt, sub_op, byte_op,
                   s_q.ir[11:6], s_q.ir[5:0]};

  // axi: address and data are taken together, one write outstanding
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.b_pend && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && !s_q.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign reserved_instr = s_q.rsvd;
  assign trap_active = s_q.trap;

  always_comb
  begin
    unique case (s_axi_awaddr)
      IFD_ADDR_INSTR: old_word = {16'h0000, s_q.ir};
      IFD_ADDR_PC: old_word = {16'h0000, s_q.pc};
      IFD_ADDR_STATUS: old_word = {28'h0000000, s_q.processor_status_word};
      default: old_word = 32'h00000000;
    endcase
  end

  assign wmerge = strb_merge(old_word, s_axi_wdata, s_axi_wstrb);
  assign res_val = wmerge[15:0];
  assign res_mask = wmerge[19:16];
  // byte results take sign and zero from the low byte
  assign res_flags = {byte_op ? res_val[IFD_SIGN_BYTE] : res_val[IFD_SIGN_WORD],
                      byte_op ? res_val[7:0] == 8'h00 : res_val == 16'h0000,
                      wmerge[20], wmerge[21]};

  always_comb
  begin
    s_d = s_q;
    s_d.exec = 1'b0;
    s_d.irq_s1 = irq_req;
    s_d.irq_s2 = s_q.irq_s1;
    if (s_q.exec)
    begin
      s_d.pc = take ? jump_tgt : pc_adv;
      s_d.tgt = jump_tgt;
      s_d.taken = take;
      s_d.rsvd = fmt == IFD_FMT_RSVD;
      if (fmt == IFD_FMT_CCOP)
      begin
        s_d.processor_status_word = s_q.ir[IFD_CC_SET_BIT] ? s_q.processor_status_word | cc_sel
                                    : s_q.processor_status_word & ~cc_sel;
      end
      if (trap_i)
      begin
        s_d.trap = 1'b1;
        s_d.ret_pc = pc_adv;
      end
      if (rti)
      begin
        s_d.trap = 1'b0;
        s_d.pc = s_q.ret_pc;
      end
    end
    else if (s_q.irq_s2 && !s_q.trap)
    begin
      // interrupt waits for any instruction in flight, then keeps its return point
      s_d.trap = 1'b1;
      s_d.ret_pc = s_q.pc;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.b_pend)
    begin
      s_d.b_pend = 1'b0;
      s_d.bvalid = 1'b1;
    end
    if (wr_go)
    begin
      s_d.b_pend = 1'b1;
      s_d.bresp = IFD_RESP_OKAY;
      unique case (s_axi_awaddr)
        IFD_ADDR_INSTR:
        begin
          s_d.ir = wmerge[15:0];
          s_d.exec = 1'b1;
        end
        IFD_ADDR_PC: s_d.pc = wmerge[15:0];
        IFD_ADDR_STATUS: s_d.processor_status_word = wmerge[3:0];
        IFD_ADDR_RESULT:
        begin
          s_d.processor_status_word = (s_q.processor_status_word & ~res_mask)
                                      | (res_flags & res_mask);
          s_d.rslt = (move_byte_op && s_q.ir[5:3] == IFD_MODE_REG)
                     ? {{8{res_val[IFD_SIGN_BYTE]}}, res_val[7:0]} : res_val;
        end
        default: s_d.bresp = IFD_RESP_DECERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = IFD_RESP_OKAY;
      unique case (s_axi_araddr)
        IFD_ADDR_INSTR: s_d.rdata = {16'h0000, s_q.ir};
        IFD_ADDR_PC: s_d.rdata = {16'h0000, s_q.pc};
        IFD_ADDR_STATUS: s_d.rdata = {28'h0000000, s_q.processor_status_word};
        IFD_ADDR_FIELDS: s_d.rdata = fields;
        IFD_ADDR_TARGET: s_d.rdata = {3'h0, opcode, s_q.trap, s_q.taken, s_q.tgt};
        IFD_ADDR_RESULT: s_d.rdata = {16'h0000, s_q.rslt};
        default:
        begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = IFD_RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.pc <= IFD_PC_RESET;
      s_q.processor_status_word <= IFD_FLAGS_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_self_jump;
    s_q.exec && s_q.ir == IFD_SELF_JUMP;
  endsequence

  sequence s_result_byte_zero;
    wr_go && s_axi_awaddr == IFD_ADDR_RESULT && s_axi_wstrb == 4'hF && byte_op
    && s_axi_wdata[7:0] == 8'h00 && s_axi_wdata[18];
  endsequence

  chk_pc_step_sop: assert property (s_q.exec && fmt == IFD_FMT_SOP
    |=> s_q.pc == $past(s_q.pc) + IFD_PC_STEP)
    else $error("pc did not advance by two");

  chk_self_jump_hold: assert property (s_self_jump
    |=> s_q.pc == $past(s_q.pc) && s_q.taken ##1 s_q.pc == $past(s_q.pc))
    else $error("self jump moved the pc");

  chk_jump_taken_target: assert property (s_q.exec && fmt == IFD_FMT_BRANCH && !loop_op
    && cond_ok |=> s_q.taken && s_q.pc == $past(s_q.pc) + IFD_PC_STEP + $past(jump_off))
    else $error("taken jump target wrong");

  chk_jump_not_taken: assert property (s_q.exec && fmt == IFD_FMT_BRANCH && !loop_op
    && !cond_ok |=> !s_q.taken && s_q.pc == $past(s_q.pc) + IFD_PC_STEP)
    else $error("untaken jump loaded target");

  chk_cc_operator_mask: assert property (s_q.exec && fmt == IFD_FMT_CCOP
    |=> ((s_q.processor_status_word ^ $past(s_q.processor_status_word))
    & ~$past(cc_sel)) == 4'h0)
    else $error("unselected flag changed");

  chk_call_fields: assert property (s_q.ir[15:9] == IFD_CALL_PREFIX
    |-> fmt == IFD_FMT_CALL && link == s_q.ir[8:6])
    else $error("call not decoded");

  chk_ret_fields: assert property (s_q.ir[15:3] == IFD_RET_PREFIX
    |-> fmt == IFD_FMT_RET && link == s_q.ir[2:0])
    else $error("return not decoded");

  chk_byte_zero_flag: assert property (s_result_byte_zero
    |=> s_q.processor_status_word[IFD_FLAG_Z])
    else $error("byte zero flag not set");

  chk_move_byte_sext: assert property (wr_go && s_axi_awaddr == IFD_ADDR_RESULT
    && move_byte_op && s_q.ir[5:3] == IFD_MODE_REG
    |=> s_q.rslt[15:8] == {8{s_q.rslt[IFD_SIGN_BYTE]}})
    else $error("byte move not sign extended");

  chk_reserved_flag: assert property (s_q.exec && fmt == IFD_FMT_RSVD
    |=> reserved_instr && s_q.pc == $past(s_q.pc) + IFD_PC_STEP)
    else $error("reserved word not flagged");

  chk_write_answer: assert property (wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");

endmodule : ifd_decoder

// [design/ifd_pkg.sv]
package ifd_pkg;

  // axi4-lite register map, byte addresses
  localparam int IFD_ADDR_W = 8;
  localparam logic [7:0] IFD_ADDR_INSTR = 8'h00;
  localparam logic [7:0] IFD_ADDR_PC = 8'h04;
  localparam logic [7:0] IFD_ADDR_STATUS = 8'h08;
  localparam logic [7:0] IFD_ADDR_FIELDS = 8'h0C;
  localparam logic [7:0] IFD_ADDR_TARGET = 8'h10;
  localparam logic [7:0] IFD_ADDR_RESULT = 8'h14;

  localparam logic [1:0] IFD_RESP_OKAY = 2'h0;
  localparam logic [1:0] IFD_RESP_DECERR = 2'h3;

  // reset values
  localparam logic [15:0] IFD_PC_RESET = 16'h0000;
  localparam logic [3:0] IFD_FLAGS_RESET = 4'h0;

  // flag positions inside the status nibble: n z v c; then instruction and result bit positions
  localparam int IFD_FLAG_N = 3;
  localparam int IFD_FLAG_Z = 2;
  localparam int IFD_BYTE_BIT = 15;
  localparam int IFD_CC_SET_BIT = 4;
  localparam int IFD_SIGN_WORD = 15;
  localparam int IFD_SIGN_BYTE = 7;

  localparam logic [15:0] IFD_PC_STEP = 16'h0002;
  localparam logic [15:0] IFD_SELF_JUMP = 16'h01FF;
  localparam logic [15:0] IFD_LOOP_DONE = 16'h0001;

  // whole-word operations
  localparam logic [15:0] IFD_OP_HALT = 16'h0000;
  localparam logic [15:0] IFD_OP_WAIT = 16'h0001;
  localparam logic [15:0] IFD_OP_RTI = 16'h0002;
  localparam logic [15:0] IFD_OP_BPT = 16'h0003;
  localparam logic [15:0] IFD_OP_IOT = 16'h0004;
  localparam logic [15:0] IFD_OP_RESET = 16'h0005;
  localparam logic [15:0] IFD_OP_RTT = 16'h0006;

  // opcode prefixes
  localparam logic [10:0] IFD_CCOP_PREFIX = 11'h005;
  localparam logic [12:0] IFD_RET_PREFIX = 13'h0010;
  localparam logic [6:0] IFD_CALL_PREFIX = 7'h04;
  localparam logic [6:0] IFD_LOOP_PREFIX = 7'h3F;
  localparam logic [6:0] IFD_EMU_TRAP_PREFIX = 7'h44;
  localparam logic [2:0] IFD_DOP_MOVE = 3'h1;
  localparam logic [2:0] IFD_DOP_ADDSUB = 3'h6;
  localparam logic [2:0] IFD_DOP_EXT = 3'h7;
  localparam logic [5:0] IFD_SOP_LO = 6'h28;
  localparam logic [5:0] IFD_SOP_HI = 6'h37;
  localparam logic [5:0] IFD_SOP_JUMP = 6'h01;
  localparam logic [5:0] IFD_SOP_SWAP = 6'h03;
  localparam logic [2:0] IFD_MODE_REG = 3'h0;

  typedef enum logic [2:0] {
    IFD_FMT_RSVD = 3'h0,
    IFD_FMT_SOP = 3'h1,
    IFD_FMT_DOP = 3'h2,
    IFD_FMT_BRANCH = 3'h3,
    IFD_FMT_CALL = 3'h4,
    IFD_FMT_RET = 3'h5,
    IFD_FMT_CCOP = 3'h6,
    IFD_FMT_TRAP = 3'h7
  } ifd_fmt_t;

  typedef struct packed {
    logic [15:0] ir;
    logic exec;
    logic [15:0] pc;
    logic [3:0] processor_status_word;
    logic [15:0] tgt;
    logic taken;
    logic [15:0] rslt;
    logic trap;
    logic [15:0] ret_pc;
    logic irq_s1;
    logic irq_s2;
    logic rsvd;
    logic b_pend;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ifd_state_t;

endpackage : ifd_pkg

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench
  import ifd_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic irq_req = 1'b0;
  logic reserved_instr;
  logic trap_active;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] br_codes [15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h80,
                                8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};
  logic [3:0] flag_set [4] = '{4'h0, 4'hF, 4'hA, 4'h5};
  logic [15:0] dop_ir [5] = '{16'h14E5, 16'h94E5, 16'h64E5, 16'hE4E5, 16'h1E72};
  logic [15:0] trap_ir [4] = '{16'h8800, 16'h8900, 16'h0003, 16'h0004};

  always #5 aclk = ~aclk;

  ifd_decoder dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_req(irq_req), .reserved_instr(reserved_instr),
    .trap_active(trap_active)
  );

  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // a hung handshake ends the run here
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  // ready is looked at on the falling edge: inputs only move after rising edges
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_done;
    logic w_done;
    logic hit;
    aw_done = 1'b0;
    w_done = 1'b0;
    hit = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge aclk);
      hit = s_axi_awvalid && s_axi_awready;
      aw_done = aw_done || hit;
      w_done = w_done || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (aw_done)
        s_axi_awvalid <= 1'b0;
      if (w_done)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    hit = 1'b0;
    while (!hit)
    begin
      @(negedge aclk);
      hit = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    hit = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!hit)
    begin
      @(negedge aclk);
      hit = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    hit = 1'b0;
    while (!hit)
    begin
      @(negedge aclk);
      hit = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hF, r);
    chk("bresp", {30'h0, IFD_RESP_OKAY}, {30'h0, r});
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] msk,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(what, exp & msk, d & msk);
  endtask : rd_chk

  // mode kind and deferred bit are the plain mode bits of each operand field
  function automatic logic [31:0] fexp(input logic rs, input logic [2:0] fmt, input logic sb,
                                       input logic by, input logic [5:0] s, input logic [5:0] d);
    return {rs, s[3], s[5:4], d[3], d[5:4], 8'h00, fmt, sb, by, s, d};
  endfunction : fexp

  function automatic logic br_taken(input logic [7:0] hb, input logic [3:0] f);
    case (hb)
      8'h01: return 1'b1;
      8'h02: return !f[2];
      8'h03: return f[2];
      8'h04: return !(f[3] ^ f[1]);
      8'h05: return f[3] ^ f[1];
      8'h06: return !(f[2] | (f[3] ^ f[1]));
      8'h07: return f[2] | (f[3] ^ f[1]);
      8'h80: return !f[3];
      8'h81: return f[3];
      8'h82: return !(f[0] | f[2]);
      8'h83: return f[0] | f[2];
      8'h84: return !f[1];
      8'h85: return f[1];
      8'h86: return !f[0];
      default: return f[0];
    endcase
  endfunction : br_taken

  initial
  begin
    logic [3:0] fl;
    logic tk;
    logic [15:0] tgt;
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("pc reset", IFD_ADDR_PC, 32'h0000_FFFF, {16'h0, IFD_PC_RESET});
    rd_chk("flags reset", IFD_ADDR_STATUS, 32'h0000_000F, 32'h0);
    // single operand, byte and word
    wr(IFD_ADDR_INSTR, 32'h0000_8A0A);
    rd_chk("sop byte", IFD_ADDR_FIELDS, 32'h8E01_F03F, fexp(0, 1, 0, 1, 0, 6'h0A));
    rd_chk("sop opcode", IFD_ADDR_TARGET, 32'h1FFC_0000, {3'h0, 11'h228, 18'h0});
    wr(IFD_ADDR_INSTR, 32'h0000_0A0A);
    rd_chk("sop word", IFD_ADDR_FIELDS, 32'h8E01_F03F, fexp(0, 1, 0, 0, 0, 6'h0A));
    foreach (dop_ir[i])
    begin
      wr(IFD_ADDR_INSTR, {16'h0, dop_ir[i]});
      rd_chk("dop", IFD_ADDR_FIELDS, 32'hFE01_FFFF, fexp(0, 2, i == 3, i == 1, dop_ir[i][11:6],
             dop_ir[i][5:0]));
    end
    // call, return and reserved words
    wr(IFD_ADDR_INSTR, 32'h0000_09F7);
    rd_chk("call r7", IFD_ADDR_FIELDS, 32'h0E0F_C03F, 32'h060F_0037);
    wr(IFD_ADDR_INSTR, 32'h0000_08CA);
    rd_chk("call r3", IFD_ADDR_FIELDS, 32'h0E0F_C03F, 32'h0807_000A);
    wr(IFD_ADDR_INSTR, 32'h0000_0083);
    rd_chk("return", IFD_ADDR_FIELDS, 32'h000F_C000, 32'h0007_4000);
    wr(IFD_ADDR_PC, 32'h0000_0040);
    wr(IFD_ADDR_INSTR, 32'h0000_0007);
    chk("reserved port", 32'h1, {31'h0, reserved_instr});
    rd_chk("reserved field", IFD_ADDR_FIELDS, 32'h8001_C000, 32'h8000_0000);
    rd_chk("reserved pc", IFD_ADDR_PC, 32'h0000_FFFF, 32'h0000_0042);
    wr(IFD_ADDR_INSTR, 32'h0000_00A0);
    chk("reserved clear", 32'h0, {31'h0, reserved_instr});
    // condition code operators over every select mask
    for (int k = 0; k < 32; k++)
    begin
      fl = k[0] ? 4'hA : 4'h5;
      wr(IFD_ADDR_STATUS, {28'h0, fl});
      wr(IFD_ADDR_INSTR, {16'h0, IFD_CCOP_PREFIX, k[4], k[3:0]});
      rd_chk("ccop flags", IFD_ADDR_STATUS, 32'hF,
             {28'h0, k[4] ? (fl | k[3:0]) : (fl & ~k[3:0])});
      rd_chk("ccop fields", IFD_ADDR_FIELDS, 32'h01F1_C000,
             {7'h0, k[3:0], k[4], 3'h0, 3'h6, 14'h0});
    end
    // result flags, byte against word
    wr(IFD_ADDR_STATUS, 32'h0);
    wr(IFD_ADDR_INSTR, 32'h0000_1083);
    wr(IFD_ADDR_RESULT, 32'h001F_0080);
    rd_chk("word flags", IFD_ADDR_STATUS, 32'hF, 32'h2);
    rd_chk("word result", IFD_ADDR_RESULT, 32'hFFFF, 32'h0080);
    wr(IFD_ADDR_INSTR, 32'h0000_9083);
    wr(IFD_ADDR_RESULT, 32'h002F_0080);
    rd_chk("byte flags", IFD_ADDR_STATUS, 32'hF, 32'h9);
    rd_chk("byte sign ext", IFD_ADDR_RESULT, 32'hFFFF, 32'hFF80);
    wr(IFD_ADDR_RESULT, 32'h0004_0100);
    rd_chk("byte zero only", IFD_ADDR_STATUS, 32'hF, 32'hD);
    wr(IFD_ADDR_INSTR, 32'h0000_1083);
    wr(IFD_ADDR_RESULT, 32'h0004_0100);
    rd_chk("word zero only", IFD_ADDR_STATUS, 32'hF, 32'h9);
    wr(IFD_ADDR_INSTR, 32'h0000_908B);
    wr(IFD_ADDR_RESULT, 32'h0000_0080);
    rd_chk("byte no ext", IFD_ADDR_RESULT, 32'hFFFF, 32'h0080);
    // every branch code against four flag patterns, both offset extremes
    foreach (br_codes[i])
      for (int k = 0; k < 4; k++)
      begin
        fl = flag_set[k];
        tk = br_taken(br_codes[i], fl);
        tgt = k[0] ? 16'h1100 : 16'h0F02;
        wr(IFD_ADDR_STATUS, {28'h0, fl});
        wr(IFD_ADDR_PC, 32'h0000_1000);
        wr(IFD_ADDR_INSTR, {16'h0, br_codes[i], k[0] ? 8'h7F : 8'h80});
        rd_chk("taken", IFD_ADDR_TARGET, 32'h0001_FFFF, {15'h0, tk, tgt});
        rd_chk("branch pc", IFD_ADDR_PC, 32'hFFFF, {16'h0, tk ? tgt : 16'h1002});
      end
    wr(IFD_ADDR_PC, 32'h0000_0200);
    wr(IFD_ADDR_INSTR, {16'h0, IFD_SELF_JUMP});
    rd_chk("self jump", IFD_ADDR_PC, 32'hFFFF, 32'h0200);
    // decrement-and-loop: count of one falls through
    for (int k = 0; k < 2; k++)
    begin
      wr(IFD_ADDR_PC, 32'h0000_0400);
      wr(IFD_ADDR_RESULT, k ? 32'h0000_0001 : 32'h0000_0005);
      wr(IFD_ADDR_INSTR, 32'h0000_7E83);
      rd_chk("loop pc", IFD_ADDR_PC, 32'hFFFF, k ? 32'h0402 : 32'h03FC);
    end
    // traps and return
    foreach (trap_ir[i])
    begin
      wr(IFD_ADDR_PC, 32'h0000_0300);
      wr(IFD_ADDR_INSTR, {16'h0, trap_ir[i]});
      chk("trap on", 32'h1, {31'h0, trap_active});
      rd_chk("trap fmt", IFD_ADDR_FIELDS, 32'h0001_C000, 32'h0001_C000);
      rd_chk("trap bit", IFD_ADDR_TARGET, 32'h0002_0000, 32'h0002_0000);
      wr(IFD_ADDR_PC, 32'h0000_0500);
      wr(IFD_ADDR_INSTR, i[0] ? {16'h0, IFD_OP_RTT} : {16'h0, IFD_OP_RTI});
      chk("trap off", 32'h0, {31'h0, trap_active});
      rd_chk("return pc", IFD_ADDR_PC, 32'hFFFF, 32'h0302);
    end
    irq_req <= 1'b1;
    for (int k = 0; k < 10 && trap_active !== 1'b1; k++)
      @(posedge aclk);
    chk("irq trap", 32'h1, {31'h0, trap_active});
    irq_req <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(IFD_ADDR_INSTR, {16'h0, IFD_OP_RTI});
    chk("irq return", 32'h0, {31'h0, trap_active});
    // bus: byte strobe, read-only and unmapped places
    wr(IFD_ADDR_PC, 32'h0000_1234);
    axi_write(IFD_ADDR_PC, 32'hFFFF_FFAB, 4'h1, r);
    rd_chk("strobe merge", IFD_ADDR_PC, 32'hFFFF, 32'h12AB);
    axi_write(IFD_ADDR_FIELDS, 32'h0, 4'hF, r);
    chk("ro write", {30'h0, IFD_RESP_DECERR}, {30'h0, r});
    axi_write(8'h20, 32'h0, 4'hF, r);
    chk("unmapped write", {30'h0, IFD_RESP_DECERR}, {30'h0, r});
    axi_read(8'h18, d, r);
    chk("unmapped read", {30'h0, IFD_RESP_DECERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    end_sim();
  end
endmodule : testbench
